// File: core/priority_interrupt_sequencer.v
// Purpose: interrupt sampling, priority pick, vectored entry and nesting
// Assumes: cpu control, memory port and poll strobe on ref_clk
// Notes:   request lines and poll data come from pins and are synced
`timescale 1ns/100ps
`include "pri_irq_consts.vh"

module priority_interrupt_sequencer (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset_n,
  // axi4-lite write address and data
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt request pins, wired-OR outside
  input  wire [15:0] irq_lines,
  // cpu instruction control
  input  wire        instr_boundary,
  output reg         fetch_go,
  input  wire        branch_and_clear_level,
  input  wire [3:0]  clear_level,
  // fast-channel sequencer
  output reg         fast_start,
  output reg  [2:0]  fast_pair_sel,
  input  wire        fast_done,
  // memory port for entry sequence
  output reg         mem_req,
  output reg         mem_we,
  output reg  [15:0] mem_addr,
  output reg  [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ack,
  // program counter
  input  wire [15:0] pc_value,
  output reg         pc_load,
  output reg  [15:0] pc_new,
  // shared-line poll
  input  wire        shared_request_poll,
  input  wire [15:0] poll_data,
  output reg         acc_load,
  output reg  [15:0] acc_data
);

  localparam [2:0] ST_IDLE   = 3'd0;
  localparam [2:0] ST_SAMPLE = 3'd1;
  localparam [2:0] ST_SELECT = 3'd2;
  localparam [2:0] ST_RDVEC  = 3'd3;
  localparam [2:0] ST_WRPC   = 3'd4;
  localparam [2:0] ST_FAST   = 3'd5;

  // lowest-numbered set bit wins; bit 4 is the found flag
  function [4:0] pick_level;
    input [15:0] req;
    integer i;
    begin
      pick_level = 5'h00;
      for (i = 15; i >= 0; i = i - 1) begin
        if (req[i]) begin
          pick_level = {1'b1, i[3:0]}; // [RULE17]
        end
      end
    end
  endfunction

  reg  [15:0] irq_meta_q;
  reg  [15:0] irq_sync_q;
  reg  [15:0] poll_meta_q;
  reg  [15:0] poll_sync_q;
  reg  [15:0] latch_q;
  reg  [15:0] mask_q;
  reg  [7:0]  fast_q;
  reg  [2:0]  state_q;
  // one stack slot per nesting depth, pushed on entry
  reg  [3:0]  act_stack_q [0:15];
  reg  [4:0]  depth_q;
  reg  [3:0]  sel_q;
  reg  [15:0] save_addr_q;
  wire [4:0]  pick;
  wire [3:0]  top_level;
  wire        higher;
  wire        wr_fire;
  wire [15:0] wmask;
  integer     k;

  // two flops on every pin input before any logic looks at it
  // so poll bits must settle two cycles ahead of the poll strobe
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_meta_q  <= 16'h0000;
      irq_sync_q  <= 16'h0000;
      poll_meta_q <= 16'h0000;
      poll_sync_q <= 16'h0000;
    end else begin
      irq_meta_q  <= irq_lines; // [RULE20]
      irq_sync_q  <= irq_meta_q;
      poll_meta_q <= poll_data;
      poll_sync_q <= poll_meta_q;
    end
  end

  // mask only hides a level from the pick; the latch itself survives
  assign pick      = pick_level(latch_q & ~mask_q); // [RULE3] [RULE18]
  // at depth zero this reads slot 15; higher ignores it then
  assign top_level = act_stack_q[depth_q[3:0] - 4'h1];
  // with nothing active any level may enter; else only a smaller number
  assign higher    = pick[4] &&
                     ((depth_q == 5'd0) || (pick[3:0] < top_level));

  // sequencing fsm
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= ST_IDLE;
      latch_q     <= 16'h0000; // [RULE21]
      depth_q     <= 5'd0;
      sel_q       <= 4'h0;
      save_addr_q <= 16'h0000;
      fetch_go    <= 1'b0;
      fast_start  <= 1'b0;
      fast_pair_sel <= 3'h0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 16'h0000;
      mem_wdata   <= 16'h0000;
      pc_load     <= 1'b0;
      pc_new      <= 16'h0000;
      for (k = 0; k < 16; k = k + 1) begin
        act_stack_q[k] <= 4'h0;
      end
    end else begin
      fetch_go   <= 1'b0;
      fast_start <= 1'b0;
      pc_load    <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // a controller-side flag clear has no path to the latch [RULE12]
          if (branch_and_clear_level) begin
            latch_q[clear_level] <= 1'b0; // [RULE13]
            if (depth_q != 5'd0 && top_level == clear_level) begin
              depth_q <= depth_q - 5'd1; // [RULE22]
            end
            state_q <= ST_SAMPLE; // relatch before next fetch [RULE15]
          end else if (instr_boundary) begin
            state_q <= ST_SAMPLE; // [RULE1] [RULE11]
          end
        end
        ST_SAMPLE: begin
          latch_q <= latch_q | irq_sync_q; // [RULE2]
          state_q <= ST_SELECT;
        end
        ST_SELECT: begin
          sel_q <= pick[3:0];
          if (!higher) begin
            fetch_go <= 1'b1; // [RULE6] [RULE11]
            state_q  <= ST_IDLE;
          end else if (pick[3] == 1'b0 && fast_q[pick[2:0]]) begin
            // only levels 0..7 can carry a fast-channel flag
            fast_pair_sel <= pick[2:0]; // [RULE4] [RULE17]
            fast_start    <= 1'b1;
            state_q       <= ST_FAST;
          end else begin
            mem_addr <= `VECTOR_BASE + {12'h000, pick[3:0]}; // [RULE5]
            mem_we   <= 1'b0;
            mem_req  <= 1'b1;
            state_q  <= ST_RDVEC;
          end
        end
        ST_RDVEC: begin
          // no sampling in these states until the new pc is set [RULE9]
          if (mem_ack) begin
            save_addr_q <= mem_rdata;
            mem_addr    <= mem_rdata; // [RULE7]
            mem_wdata   <= pc_value;
            mem_we      <= 1'b1;
            state_q     <= ST_WRPC;
          end
        end
        ST_WRPC: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            pc_new  <= save_addr_q + `PC_STEP; // [RULE8]
            pc_load <= 1'b1;
            act_stack_q[depth_q[3:0]] <= sel_q; // [RULE22]
            depth_q <= depth_q + 5'd1;
            state_q <= ST_SAMPLE; // nested check before fetch [RULE10]
          end
        end
        ST_FAST: begin
          // hardware transfer, no program level is pushed
          // the latch stays set and only branch-and-clear or reset clears it,
          // so the same level is served again at the next pick
          if (fast_done) begin
            state_q <= ST_SAMPLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // poll: controllers drive their status bits, word goes to accumulator
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_load <= 1'b0;
      acc_data <= 16'h0000;
    end else begin
      acc_load <= shared_request_poll; // [RULE16]
      if (shared_request_poll) begin
        acc_data <= poll_sync_q; // already wired-OR on the bus [RULE14]
      end
    end
  end

  // axi4-lite write: address and data taken together, one at a time
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q      <= `MASK_RESET;
      fast_q      <= `FAST_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (s_axi_awaddr == `REG_MASK) begin
          // byte lanes 0 and 1 cover all sixteen mask bits
          mask_q <= (mask_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
        end else if (s_axi_awaddr == `REG_FAST) begin
          if (s_axi_wstrb[0]) begin
            fast_q <= s_axi_wdata[7:0];
          end
        end else if (s_axi_awaddr == `REG_PENDING ||
                     s_axi_awaddr == `REG_ACTIVE) begin
          s_axi_bresp <= `RESP_OKAY; // read-only, write ignored
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
    end
  end

  // axi4-lite read: one outstanding, data registered
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        if (s_axi_araddr == `REG_MASK) begin
          s_axi_rdata[15:0] <= mask_q;
        end else if (s_axi_araddr == `REG_FAST) begin
          s_axi_rdata[7:0] <= fast_q;
        end else if (s_axi_araddr == `REG_PENDING) begin
          s_axi_rdata[15:0] <= latch_q;
        end else if (s_axi_araddr == `REG_ACTIVE) begin
          // busy is high for any step between boundary and fetch
          s_axi_rdata[`ACT_LEVEL_LSB +: 4] <= top_level;
          s_axi_rdata[`ACT_DEPTH_LSB +: 5] <= depth_q;
          s_axi_rdata[`ACT_BUSY_BIT] <= (state_q != ST_IDLE);
        end else begin
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
    end
  end

endmodule

// File: shared/pri_irq_consts.vh
// Purpose: constants for the priority interrupt sequencer
// Assumes: 16 external levels, 16-bit memory words, AXI4-Lite 32-bit data
// Notes:   offsets are byte addresses of aligned 32-bit words
// Contract
// RULE1: sample request lines only at instruction boundaries
// RULE2: every asserted line sets its own latch
// RULE3: pick highest-priority unmasked latched level
// RULE4: fast-channel level forms pair address, starts sequencer
// RULE5: other level gives vector address, starts entry
// RULE6: nothing unmasked pending means plain fetch
// RULE7: read vector word, store PC there
// RULE8: load PC with save address plus one
// RULE9: no sampling during entry until PC loaded
// RULE10: resample after entry, nest only for higher level
// RULE11: after each instruction preempt only higher level
// RULE12: controller flag clear leaves latch unchanged
// RULE13: branch-and-clear clears the named level latch
// RULE14: controllers share a line by wired-OR
// RULE15: still-asserted shared line relatches before next fetch
// RULE16: poll command loads shared status word into accumulator
// RULE17: level 0 highest; fast levels share numbers
// RULE18: masking never clears a pending request
// RULE19: controller holds request until serviced
// RULE20: sixteen external request lines accepted
// RULE21: reset clears latches and active record
// RULE22: active level stacked per nesting depth
`ifndef PRI_IRQ_CONSTS_VH
`define PRI_IRQ_CONSTS_VH

`define NUM_LEVELS      16
`define NUM_FAST        8
`define VECTOR_BASE     16'h0010
`define PC_STEP         16'h0001

`define REG_MASK        12'h000
`define REG_FAST        12'h004
`define REG_PENDING     12'h008
`define REG_ACTIVE      12'h00C

`define MASK_RESET      16'h0000
`define FAST_RESET      8'h00

`define ACT_LEVEL_LSB   0
`define ACT_DEPTH_LSB   4
`define ACT_BUSY_BIT    12

`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// File: bench/irq_ctrl_model.sv
// Purpose: peripheral controllers that raise the request lines
// Assumes: one flag per line plus four controllers on one shared line
// Notes:   poll bits stay driven between polls, a simplification
`timescale 1ns/100ps
module irq_ctrl_model #(
  parameter SHARED_LINE = 7
) (
  // clock
  input  wire        ref_clk,
  // set pulses and service clears
  input  wire [15:0] set_req,
  input  wire [15:0] svc_clr,
  input  wire [3:0]  sh_set,
  input  wire [3:0]  sh_clr,
  // bus side
  output wire [15:0] irq_lines,
  output wire [15:0] poll_data
);
  reg [15:0] flag_q  = 16'h0000;
  reg [3:0]  share_q = 4'h0;
  // a short set pulse is held until the service clear
  always @(posedge ref_clk) begin
    flag_q  <= (flag_q | set_req) & ~svc_clr;
    share_q <= (share_q | sh_set) & ~sh_clr;
  end
  // any shared controller holds its line up alone
  assign irq_lines = flag_q |
                     ({15'h0000, |share_q} << SHARED_LINE);
  // each shared controller answers on its own data bit
  assign poll_data = {12'h000, share_q};
endmodule

// File: bench/irq_seq_assertions.sv
// Purpose: port-level checks for the interrupt sequencer
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every sequencer instance
`timescale 1ns/100ps
module irq_seq_chk (
  // clock and reset
  input wire        ref_clk,
  input wire        reset_n,
  // cpu control
  input wire        instr_boundary,
  input wire        fetch_go,
  input wire        fast_start,
  // memory port
  input wire        mem_req,
  input wire        mem_we,
  input wire [15:0] mem_addr,
  input wire [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  input wire        mem_ack,
  // pc and poll
  input wire [15:0] pc_value,
  input wire        pc_load,
  input wire [15:0] pc_new,
  input wire        shared_request_poll,
  input wire        acc_load
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // entry steps: vector read, then pc save write
  sequence vec_read; mem_req && !mem_we && mem_ack; endsequence
  sequence save_done; mem_req && mem_we && mem_ack; endsequence
  vec_addr_a: assert property (
    $rose(mem_req) |-> !mem_we && mem_addr[15:4] == 12'h001)
    else $error("entry did not read a vector cell");
  pc_save_a: assert property (
    vec_read |=> mem_we && mem_addr == $past(mem_rdata)
      && mem_wdata == $past(pc_value))
    else $error("pc not stored at the vector word");
  pc_inc_a: assert property (
    save_done |=> pc_load && !mem_req
      && pc_new == $past(mem_addr) + 16'h0001)
    else $error("new pc is not save address plus one");
  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before ack");
  entry_quiet_a: assert property (
    mem_req |-> !fetch_go && !fast_start)
    else $error("service started during entry");
  fetch_wait_a: assert property (
    instr_boundary |=> !fetch_go [*2])
    else $error("fetch before sampling");
  poll_load_a: assert property (
    shared_request_poll |=> acc_load)
    else $error("poll did not load accumulator");
  acc_cause_a: assert property (
    acc_load |-> $past(shared_request_poll))
    else $error("accumulator load without poll");
  reset_quiet_a: assert property (
    $rose(reset_n) |-> !mem_req && !pc_load && !fetch_go)
    else $error("sequence active out of reset");
endmodule
bind priority_interrupt_sequencer irq_seq_chk u_chk (.ref_clk, .reset_n,
  .instr_boundary, .fetch_go, .fast_start, .mem_req, .mem_we, .mem_addr,
  .mem_wdata, .mem_rdata, .mem_ack, .pc_value, .pc_load, .pc_new,
  .shared_request_poll, .acc_load);

// File: bench/priority_interrupt_sequencer_tb.sv
// Purpose: directed run of sampling, entry, nesting, clear and poll
// Assumes: mask bit high disables its level
// Notes:   memory answers vector reads with 0x1000 plus level times 0x100
`timescale 1ns/100ps
`include "pri_irq_consts.vh"
module priority_interrupt_sequencer_tb;
  reg        ref_clk = 1'b0, reset_n = 1'b0;
  reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, a;
  reg [31:0] s_axi_wdata = 32'h00000000;
  reg [3:0]  s_axi_wstrb = 4'hF, clear_level = 4'h0;
  reg        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mem_ack = 1'b0;
  reg        instr_boundary = 1'b0, branch_and_clear_level = 1'b0;
  reg        fast_done = 1'b0, shared_request_poll = 1'b0;
  reg [15:0] mem_rdata = 16'h0000, pc_value = 16'h3A5C;
  reg [15:0] set_req = 16'h0000, svc_clr = 16'h0000;
  reg [3:0]  sh_set = 4'h0, sh_clr = 4'h0;
  reg [1:0]  wait_q = 2'h0;
  integer    n_fail = 0, n_tests = 0, cyc = 0;
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire       s_axi_rvalid, fetch_go, fast_start, mem_req, mem_we;
  wire       pc_load, acc_load;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0] fast_pair_sel;
  wire [15:0] irq_lines, poll_data, mem_addr, mem_wdata, pc_new, acc_data;
  always #4 ref_clk = ~ref_clk;
  priority_interrupt_sequencer DUT (.ref_clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_lines,
    .instr_boundary, .fetch_go, .branch_and_clear_level, .clear_level,
    .fast_start, .fast_pair_sel, .fast_done, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .pc_value, .pc_load, .pc_new,
    .shared_request_poll, .poll_data, .acc_load, .acc_data);
  irq_ctrl_model peers (.ref_clk, .set_req, .svc_clr, .sh_set, .sh_clr,
    .irq_lines, .poll_data);
  // slow memory and fast-channel partner, plus the run limit
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    fast_done <= fast_start;
    cyc <= cyc + 1;
    if (mem_req && !mem_ack) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == 2'h2) begin
        mem_ack <= 1'b1;
        mem_rdata <= {mem_addr[7:0], 8'h00};
        wait_q <= 2'h0;
      end
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  task cmp(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task axi_wr(input [11:0] ad, input [31:0] d, input [1:0] r);
    begin
      @(posedge ref_clk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cmp({30'h0, s_axi_bresp}, {30'h0, r});
    end
  endtask
  task axi_rd(input [11:0] ad, input [31:0] e, input [1:0] r);
    begin
      @(posedge ref_clk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cmp({30'h0, s_axi_rresp}, {30'h0, r});
      cmp(s_axi_rdata, e);
    end
  endtask
  // controller set and service pulses, then time for the pin synchroniser
  task flags(input [15:0] s, input [15:0] c, input [3:0] hs, input [3:0] hc);
    begin
      @(posedge ref_clk);
      set_req <= s;
      svc_clr <= c;
      sh_set <= hs;
      sh_clr <= hc;
      @(posedge ref_clk);
      set_req <= 16'h0000;
      svc_clr <= 16'h0000;
      sh_set <= 4'h0;
      sh_clr <= 4'h0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
  // boundary or clear pulse; outcome is new pc, 0xFA0n fast, 0xFFFF fetch
  task run(input bac, input [3:0] lv, input [15:0] e);
    reg [15:0] r;
    begin
      @(posedge ref_clk);
      instr_boundary <= !bac;
      branch_and_clear_level <= bac;
      clear_level <= lv;
      @(posedge ref_clk);
      instr_boundary <= 1'b0;
      branch_and_clear_level <= 1'b0;
      r = 16'h0000;
      while (r == 16'h0000) begin
        @(posedge ref_clk);
        if (pc_load === 1'b1) r = pc_new;
        else if (fast_start === 1'b1) r = {13'h1F40, fast_pair_sel};
        else if (fetch_go === 1'b1) r = 16'hFFFF;
      end
      cmp({16'h0000, r}, {16'h0000, e});
      while (r[15:12] != 4'hF && fetch_go !== 1'b1) @(posedge ref_clk);
    end
  endtask
  task wrap_up;
    begin
      $display("tests=%0d fails=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (a = 12'h000; a <= `REG_ACTIVE; a = a + 12'h004)
      axi_rd(a, 32'h0, `RESP_OKAY);
    axi_rd(12'h010, 32'h0, `RESP_SLVERR);
    axi_wr(12'h010, 32'h0, `RESP_SLVERR);
    run(1'b0, 4'h0, 16'hFFFF);
    flags(16'h0020, 16'h0, 4'h0, 4'h0);
    run(1'b0, 4'h0, 16'h1501);
    axi_rd(`REG_ACTIVE, 32'h15, `RESP_OKAY);
    flags(16'h0200, 16'h0, 4'h0, 4'h0);
    run(1'b0, 4'h0, 16'hFFFF);
    flags(16'h0004, 16'h0, 4'h0, 4'h0);
    run(1'b0, 4'h0, 16'h1201);
    axi_rd(`REG_ACTIVE, 32'h22, `RESP_OKAY);
    flags(16'h0, 16'h0004, 4'h0, 4'h0);
    axi_rd(`REG_PENDING, 32'h0224, `RESP_OKAY);
    run(1'b1, 4'h2, 16'hFFFF);
    axi_rd(`REG_ACTIVE, 32'h15, `RESP_OKAY);
    axi_wr(`REG_MASK, 32'h0200, `RESP_OKAY);
    run(1'b1, 4'h5, 16'h1501);
    flags(16'h0, 16'h0020, 4'h0, 4'h0);
    run(1'b1, 4'h5, 16'hFFFF);
    axi_rd(`REG_PENDING, 32'h0200, `RESP_OKAY);
    axi_wr(`REG_MASK, 32'h0, `RESP_OKAY);
    run(1'b0, 4'h0, 16'h1901);
    flags(16'h0, 16'h0200, 4'h0, 4'h0);
    run(1'b1, 4'h9, 16'hFFFF);
    axi_rd(`REG_ACTIVE, 32'h0, `RESP_OKAY);
    // a line raised mid-entry waits for the resample, then nests
    flags(16'h0100, 16'h0, 4'h0, 4'h0);
    fork
      run(1'b0, 4'h0, 16'h1801);
      begin
        repeat (3) @(posedge ref_clk);
        flags(16'h0002, 16'h0, 4'h0, 4'h0);
      end
    join
    axi_rd(`REG_PENDING, 32'h0102, `RESP_OKAY);
    axi_rd(`REG_ACTIVE, 32'h21, `RESP_OKAY);
    // reset in mid-service must drop latches and the active record
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    axi_rd(`REG_PENDING, 32'h0, `RESP_OKAY);
    axi_rd(`REG_ACTIVE, 32'h0, `RESP_OKAY);
    flags(16'h0, 16'h0102, 4'h0, 4'h0);
    flags(16'h0, 16'h0, 4'h5, 4'h0);
    @(posedge ref_clk);
    shared_request_poll <= 1'b1;
    @(posedge ref_clk);
    shared_request_poll <= 1'b0;
    @(posedge ref_clk);
    cmp({15'h0, acc_load, acc_data}, 32'h00010005);
    flags(16'h0, 16'h0, 4'h0, 4'h5);
    axi_wr(`REG_FAST, 32'h08, `RESP_OKAY);
    flags(16'h0008, 16'h0, 4'h0, 4'h0);
    run(1'b0, 4'h0, 16'hFA03);
    wrap_up;
  end
endmodule
